/* File: pbcc_defs.svh */
// Purpose: Offsets, field positions, reset values and timing constants.
// Assumes: One 100 MHz clock; registers on a plain strobe port.
// Notes: Definitions only.
`ifndef PBCC_DEFS_SVH
`define PBCC_DEFS_SVH
`define PBCC_OFF_CMD 4'h0
`define PBCC_OFF_PSEL 4'h4
`define PBCC_OFF_STAT 4'h8
`define PBCC_OFF_CTRL 4'hc
`define PBCC_CTRL_RESET 16'h1210
`define PBCC_CTRL_WMASK 16'h48e4
`define PBCC_CTRL_EE_BUSY 16'h0003
`define PBCC_PSEL_RESET 6'h00
`define PBCC_BIT_BAD_CRC 14
`define PBCC_BIT_AUTO_REL 11
`define PBCC_BIT_LINK_EN 7
`define PBCC_BIT_ROLL_EN 6
`define PBCC_BIT_TXERR_EN 5
`define PBCC_BIT_EE_SEL 2
`define PBCC_BIT_RELOAD 1
`define PBCC_BIT_STORE 0
`define PBCC_CMD_MSB 7
`define PBCC_CMD_LSB 5
`define PBCC_BIT_BUSY 0
`define PBCC_CLK_PERIOD_NS 10
`define PBCC_EE_MAX_NS 750000
`define PBCC_EE_CNT_W 17
`define PBCC_TGT_GENERAL 4'h8
`define PBCC_TGT_LOAD 4'h7
`define PBCC_TGT_STORE 4'h3
`endif

/* File: pbcc_pkg.sv */
// Purpose: Types shared by the packet buffer command control modules.
// Assumes: Command codes follow declaration order 0 to 7.
// Notes: The decode function is used by the top and the tracker.
package pbcc_pkg;
  typedef enum logic [2:0] {
    CMD_NOOP, CMD_ALLOC, CMD_MM_RESET, CMD_RX_POP,
    CMD_RX_POP_FREE, CMD_FREE_PKT, CMD_TX_ENQ, CMD_TX_QCLR
  } pbcc_cmd_e;

  typedef enum {EE_IDLE, EE_LOAD, EE_STORE} pbcc_ee_state_e;

  function automatic logic [7:0] pbcc_decode(input pbcc_cmd_e cmd);
    pbcc_decode = 8'h01 << cmd;
  endfunction : pbcc_decode
endpackage : pbcc_pkg

/* File: pbcc_link_if.sv */
// Purpose: Carries requests and status between the top and its helpers.
// Assumes: All signals are in the mclk domain.
// Notes: Strobes are one cycle long.
`timescale 1ns/1ps
interface pbcc_link_if;
  import pbcc_pkg::*;
  logic ee_start_load;
  logic ee_start_store;
  logic ee_general_only;
  logic ee_running;
  logic ee_finished;
  logic mm_cmd_stb;
  pbcc_cmd_e mm_cmd;
  logic mm_busy;
  logic mm_failed;
  modport main (output ee_start_load, ee_start_store, ee_general_only,
    mm_cmd_stb, mm_cmd, input ee_running, ee_finished, mm_busy, mm_failed);
  modport ee (input ee_start_load, ee_start_store, ee_general_only,
    output ee_running, ee_finished);
  modport mm (input mm_cmd_stb, mm_cmd, output mm_busy, mm_failed);
endinterface : pbcc_link_if

/* File: pbcc_ee_seq.sv */
// Purpose: Tracks one EEPROM load or save and bounds its duration.
// Assumes: The serial engine outside reports completion on ee_done.
// Notes: A stalled engine is cut off at the time limit.
`timescale 1ns/1ps
`include "pbcc_defs.svh"
module pbcc_ee_seq #(
  parameter int unsigned EE_LIMIT = `PBCC_EE_MAX_NS / `PBCC_CLK_PERIOD_NS
) (
  input wire logic mclk, // Clock.
  input wire logic srst, // Synchronous reset.
  input wire logic ce, // Clock enable.
  input wire logic ee_done, // Engine finished.
  pbcc_link_if.ee lnk, // Start and status.
  output logic ee_load_start, // Load request pulse.
  output logic ee_store_start, // Save request pulse.
  output logic [3:0] ee_targets // Registers touched.
);
  import pbcc_pkg::*;
  pbcc_ee_state_e state_reg;
  logic [`PBCC_EE_CNT_W-1:0] cnt_reg;
  logic finished_reg;
  wire logic idle = (state_reg == EE_IDLE);
  wire logic timeout = (cnt_reg == `PBCC_EE_CNT_W'(EE_LIMIT - 1));
  wire logic end_now = !idle && (ee_done || timeout);
  wire logic [3:0] tgt_next = lnk.ee_general_only ? `PBCC_TGT_GENERAL :
    (lnk.ee_start_load ? `PBCC_TGT_LOAD : `PBCC_TGT_STORE);

  assign lnk.ee_running = !idle;
  assign lnk.ee_finished = finished_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= EE_IDLE;
      cnt_reg <= '0;
      finished_reg <= 1'b0;
      ee_load_start <= 1'b0;
      ee_store_start <= 1'b0;
      ee_targets <= 4'h0;
    end else if (ce) begin
      finished_reg <= end_now;
      ee_load_start <= idle && lnk.ee_start_load;
      ee_store_start <= idle && !lnk.ee_start_load && lnk.ee_start_store;
      cnt_reg <= idle ? '0 : cnt_reg + 1'b1;
      case (state_reg)
        EE_IDLE: begin
          if (lnk.ee_start_load || lnk.ee_start_store) begin
            ee_targets <= tgt_next;
            state_reg <= lnk.ee_start_load ? EE_LOAD : EE_STORE;
          end
        end
        EE_LOAD, EE_STORE: begin
          if (end_now) state_reg <= EE_IDLE;
        end
        default: state_reg <= EE_IDLE;
      endcase
    end
  end
endmodule : pbcc_ee_seq

/* File: pbcc_mm_track.sv */
// Purpose: Holds the release-busy and allocation-failed flags.
// Assumes: Commands arrive in the cycle after the write strobe, as the strobe ends.
// Notes: A new command wins over a completion in the same cycle.
`timescale 1ns/1ps
module pbcc_mm_track (
  input wire logic mclk, // Clock.
  input wire logic srst, // Synchronous reset.
  input wire logic ce, // Clock enable.
  input wire logic alloc_ok, // Allocation satisfied.
  input wire logic release_done, // Page release finished.
  pbcc_link_if.mm lnk // Commands and flags.
);
  import pbcc_pkg::*;
  logic busy_reg;
  logic failed_reg;
  wire logic [7:0] op = lnk.mm_cmd_stb ? pbcc_decode(lnk.mm_cmd) : 8'h00;
  wire logic rel_cmd = op[CMD_RX_POP_FREE] | op[CMD_FREE_PKT];

  assign lnk.mm_busy = busy_reg;
  assign lnk.mm_failed = failed_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      failed_reg <= 1'b1;
    end else if (ce) begin
      busy_reg <= rel_cmd | (busy_reg & ~release_done
        & ~op[CMD_MM_RESET]);
      failed_reg <= op[CMD_ALLOC] | op[CMD_MM_RESET]
        | (failed_reg & ~alloc_ok);
    end
  end
endmodule : pbcc_mm_track

/* File: pbcc_top.sv */
// Purpose: Host control register and buffer manager command register.
// Assumes: Event inputs are synchronous to mclk and one cycle wide.
// Notes: Pages, queues and the EEPROM engine live outside this block.
`timescale 1ns/1ps
`include "pbcc_defs.svh"
module pbcc_top #(
  parameter int unsigned EE_LIMIT = `PBCC_EE_MAX_NS / `PBCC_CLK_PERIOD_NS
) (
  input wire logic mclk, // Clock, 100 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable.
  input wire logic [3:0] addr, // Register byte address.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr_stb, // Write strobe.
  input wire logic rd_stb, // Read strobe.
  output logic [15:0] rdata, // Read data, cycle after strobe.
  input wire logic rx_frame_done, // Received frame stored.
  input wire logic rx_crc_bad, // That frame failed its CRC.
  input wire logic tx_done, // Transmit attempt finished.
  input wire logic tx_ok, // Attempt was successful.
  input wire logic tx_queue_empty, // No packets left to send.
  input wire logic transmitter_on, // Transmitter enable level.
  input wire logic tx_success_flag, // Last transmit succeeded.
  input wire logic txon_write_one, // Host wrote 1 to transmitter_on.
  input wire logic link_ok, // Link good level.
  input wire logic counter_wrapped, // Counter wrap flag level.
  input wire logic counter_reg_read, // Host read the counter register.
  input wire logic ee_done, // EEPROM engine finished.
  input wire logic alloc_ok, // Allocation request satisfied.
  input wire logic release_done, // Page release finished.
  output logic rx_keep, // Push frame on receive queue.
  output logic rx_free, // Free frame pages, no queueing.
  output logic rx_irq, // Receive interrupt pulse.
  output logic tx_release, // Free pages of sent packet.
  output logic tx_complete_push, // Push packet on completion queue.
  output logic tx_irq, // Transmit interrupt pulse.
  output logic tx_empty_irq, // Queue drained interrupt pulse.
  output logic txon_clear, // Clear transmitter_on pulse.
  output logic merged_event_irq, // Merged event interrupt level.
  output logic [7:0] mm_op, // One-hot command pulse by code.
  output logic [5:0] mm_pkt, // Packet number with mm_op.
  output logic ee_load_start, // EEPROM load request pulse.
  output logic ee_store_start, // EEPROM save request pulse.
  output logic [3:0] ee_targets // Registers the EEPROM op touches.
);
  import pbcc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers and shared carrier
  // ----------------------------------------------------------------
  pbcc_link_if lnk ();

  pbcc_ee_seq #(.EE_LIMIT(EE_LIMIT)) u_ee (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .ee_done(ee_done),
    .lnk(lnk),
    .ee_load_start(ee_load_start),
    .ee_store_start(ee_store_start),
    .ee_targets(ee_targets)
  );

  pbcc_mm_track u_mm (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .alloc_ok(alloc_ok),
    .release_done(release_done),
    .lnk(lnk)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic reload_reg;
  logic store_reg;
  logic boot_reg;
  logic [5:0] psel_reg;
  logic cmd_pend_reg;
  pbcc_cmd_e cmd_hold_reg;
  logic link_prev_reg;
  logic roll_prev_reg;
  logic txon_prev_reg;
  logic link_lat_reg;
  logic roll_lat_reg;
  logic txerr_lat_reg;

  // ----------------------------------------------------------------
  // Address decode and access qualification
  // ----------------------------------------------------------------
  // The EEPROM bits stay high from the request until the helper
  // reports completion, so the helper's own running flag is not needed
  // to gate host accesses.
  wire logic ee_active = reload_reg | store_reg;
  wire logic sel_cmd = (addr == `PBCC_OFF_CMD);
  wire logic sel_psel = (addr == `PBCC_OFF_PSEL);
  wire logic sel_stat = (addr == `PBCC_OFF_STAT);
  wire logic sel_ctrl = (addr == `PBCC_OFF_CTRL);
  wire logic wr_ok = wr_stb & ~ee_active;
  wire logic wr_cmd = wr_ok & sel_cmd;
  wire logic wr_psel = wr_ok & sel_psel;
  wire logic wr_ctrl = wr_ok & sel_ctrl;

  // Command code sits in the top three bits of the low byte.
  wire pbcc_cmd_e cmd_code =
    pbcc_cmd_e'(wdata[`PBCC_CMD_MSB:`PBCC_CMD_LSB]);

  // Command issued one cycle after its strobe, at the strobe's end.
  wire logic cmd_issue = cmd_pend_reg;
  wire logic [7:0] op_hot = cmd_issue ? pbcc_decode(cmd_hold_reg)
    : 8'h00;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  wire logic accept_bad_crc = ctrl_reg[`PBCC_BIT_BAD_CRC];
  wire logic auto_release = ctrl_reg[`PBCC_BIT_AUTO_REL];
  wire logic link_change_irq_en = ctrl_reg[`PBCC_BIT_LINK_EN];
  wire logic rollover_irq_en = ctrl_reg[`PBCC_BIT_ROLL_EN];
  wire logic tx_error_irq_en = ctrl_reg[`PBCC_BIT_TXERR_EN];
  wire logic ee_sel_general = ctrl_reg[`PBCC_BIT_EE_SEL];

  wire logic [15:0] ctrl_next = (ctrl_reg & ~`PBCC_CTRL_WMASK)
    | (wdata & `PBCC_CTRL_WMASK);
  wire logic start_load = wr_ctrl & wdata[`PBCC_BIT_RELOAD];
  wire logic start_store = wr_ctrl & wdata[`PBCC_BIT_STORE]
    & ~wdata[`PBCC_BIT_RELOAD];

  // Host clearing an enable in this cycle; used for acknowledge.
  wire logic link_en_clr = wr_ctrl & ~wdata[`PBCC_BIT_LINK_EN];
  wire logic txerr_en_clr = wr_ctrl & ~wdata[`PBCC_BIT_TXERR_EN];

  // The boot reload uses the select reset value, so setup registers.
  assign lnk.ee_start_load = start_load | boot_reg;
  assign lnk.ee_start_store = start_store;
  assign lnk.ee_general_only = wr_ctrl ? wdata[`PBCC_BIT_EE_SEL]
    : ee_sel_general;
  assign lnk.mm_cmd_stb = cmd_issue;
  assign lnk.mm_cmd = cmd_hold_reg;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  wire logic link_evt = link_ok ^ link_prev_reg;
  wire logic roll_evt = counter_wrapped & ~roll_prev_reg;
  wire logic txerr_evt = txon_prev_reg & ~transmitter_on
    & ~tx_success_flag;

  // A new event wins over an acknowledge in the same cycle.
  wire logic link_lat_next = link_evt
    | (link_lat_reg & link_change_irq_en & ~link_en_clr);
  wire logic roll_lat_next = roll_evt
    | (roll_lat_reg & ~counter_reg_read);
  wire logic txerr_lat_next = txerr_evt
    | (txerr_lat_reg & tx_error_irq_en & ~txerr_en_clr
       & ~txon_write_one);

  wire logic merged_next = (link_lat_reg & link_change_irq_en)
    | (roll_lat_reg & rollover_irq_en)
    | (txerr_lat_reg & tx_error_irq_en);

  // ----------------------------------------------------------------
  // Receive and transmit completion routing
  // ----------------------------------------------------------------
  wire logic rx_take = rx_frame_done & (accept_bad_crc | ~rx_crc_bad);
  wire logic rx_drop = rx_frame_done & ~accept_bad_crc
    & rx_crc_bad;

  // Under auto release a good packet leaves no trace in the
  // completion queue; a failed one stays queued with its pages held
  // so software can inspect it and restart the run.
  wire logic tx_good_auto = tx_done & tx_ok & auto_release;
  wire logic tx_bad_auto = tx_done & ~tx_ok & auto_release;
  wire logic tx_manual = tx_done & ~auto_release;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire logic [15:0] stat_word = {10'h000, lnk.ee_running, txerr_lat_reg,
    roll_lat_reg, link_lat_reg, lnk.mm_failed, lnk.mm_busy};
  wire logic [15:0] ctrl_word = {ctrl_reg[15:2], reload_reg, store_reg};
  wire logic [15:0] rd_mux =
    ee_active ? (sel_ctrl ? `PBCC_CTRL_EE_BUSY : 16'h0000) :
    sel_cmd ? {15'h0000, lnk.mm_busy} :
    sel_psel ? {10'h000, psel_reg} :
    sel_stat ? stat_word :
    sel_ctrl ? ctrl_word : 16'h0000;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= rd_stb ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Control register and EEPROM status bits
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_reg <= `PBCC_CTRL_RESET;
      boot_reg <= 1'b1;
    end else if (ce) begin
      boot_reg <= 1'b0;
      if (wr_ctrl) ctrl_reg <= ctrl_next;
    end
  end

  // Set wins over the completion pulse; the request is only accepted
  // while idle, so both cannot really coincide.
  always_ff @(posedge mclk) begin
    if (srst) begin
      reload_reg <= 1'b0;
      store_reg <= 1'b0;
    end else if (ce) begin
      reload_reg <= lnk.ee_start_load
        | (reload_reg & ~lnk.ee_finished);
      store_reg <= start_store
        | (store_reg & ~lnk.ee_finished);
    end
  end

  // ----------------------------------------------------------------
  // Command capture and packet select
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd_pend_reg <= 1'b0;
      cmd_hold_reg <= CMD_NOOP;
    end else if (ce) begin
      cmd_pend_reg <= wr_cmd;
      if (wr_cmd) cmd_hold_reg <= cmd_code;
    end
  end

  // A reset command issued in the same cycle as a new select write
  // loses to the write, which is the later host action.
  always_ff @(posedge mclk) begin
    if (srst) begin
      psel_reg <= `PBCC_PSEL_RESET;
    end else if (ce) begin
      if (wr_psel) psel_reg <= wdata[5:0];
      else if (op_hot[CMD_MM_RESET]) psel_reg <= `PBCC_PSEL_RESET;
    end
  end

  // Commands go out with the packet select value of the issue cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      mm_op <= 8'h00;
      mm_pkt <= 6'h00;
    end else if (ce) begin
      mm_op <= {op_hot[7:1], 1'b0};
      mm_pkt <= psel_reg;
    end
  end

  // ----------------------------------------------------------------
  // Event latches and merged interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      link_prev_reg <= 1'b0;
      roll_prev_reg <= 1'b0;
      txon_prev_reg <= 1'b0;
    end else if (ce) begin
      link_prev_reg <= link_ok;
      roll_prev_reg <= counter_wrapped;
      txon_prev_reg <= transmitter_on;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      link_lat_reg <= 1'b0;
      roll_lat_reg <= 1'b0;
      txerr_lat_reg <= 1'b0;
      merged_event_irq <= 1'b0;
    end else if (ce) begin
      link_lat_reg <= link_lat_next;
      roll_lat_reg <= roll_lat_next;
      txerr_lat_reg <= txerr_lat_next;
      merged_event_irq <= merged_next;
    end
  end

  // ----------------------------------------------------------------
  // Receive routing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_keep <= 1'b0;
      rx_free <= 1'b0;
      rx_irq <= 1'b0;
    end else if (ce) begin
      rx_keep <= rx_take;
      rx_free <= rx_drop;
      rx_irq <= rx_take;
    end
  end

  // ----------------------------------------------------------------
  // Transmit completion routing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_release <= 1'b0;
      tx_complete_push <= 1'b0;
      tx_irq <= 1'b0;
      tx_empty_irq <= 1'b0;
      txon_clear <= 1'b0;
    end else if (ce) begin
      tx_release <= tx_good_auto;
      tx_complete_push <= tx_manual | tx_bad_auto;
      tx_irq <= tx_manual | tx_bad_auto;
      tx_empty_irq <= tx_good_auto & tx_queue_empty;
      txon_clear <= tx_bad_auto;
    end
  end
endmodule : pbcc_top

/* File: pbcc_checker.sv */
// Purpose: Port-level assertions for the packet buffer command control.
// Assumes: Bound to pbcc_top; inner enables are invisible here.
// Notes: Checks tie each output pulse except tx_empty_irq and the EEPROM start pulses to its cause at the inputs.
`timescale 1ns/1ps
module pbcc_checker (
  input wire logic mclk, // Clock.
  input wire logic srst, // Reset.
  input wire logic ce, // Clock enable.
  input wire logic wr_stb, // Write strobe.
  input wire logic [15:0] wdata, // Write data.
  input wire logic rx_frame_done, // Frame stored.
  input wire logic rx_crc_bad, // Bad CRC.
  input wire logic tx_done, // Transmit done.
  input wire logic tx_ok, // Transmit good.
  input wire logic rx_keep, // Keep frame.
  input wire logic rx_free, // Free frame.
  input wire logic rx_irq, // Receive irq.
  input wire logic tx_release, // Free sent pages.
  input wire logic tx_complete_push, // Completion push.
  input wire logic tx_irq, // Transmit irq.
  input wire logic txon_clear, // Stop transmitter.
  input wire logic [7:0] mm_op, // Command pulse.
  input wire logic ee_load_start, // Load start.
  input wire logic ee_store_start, // Save start.
  input wire logic [3:0] ee_targets // Targets.
);
  // A frozen clock enable stretches pulses, so those cycles are skipped.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || !ce);
  good_frame_a: assert property (
    rx_frame_done && !rx_crc_bad |=> rx_keep && rx_irq) else $error("lost");
  frame_fate_a: assert property (
    rx_frame_done |=> rx_keep != rx_free) else $error("frame fate");
  sent_ok_a: assert property (
    tx_done && tx_ok |=> tx_release != tx_complete_push) else $error("ok");
  sent_bad_a: assert property (
    tx_done && !tx_ok |=> tx_irq && tx_complete_push && !tx_release)
    else $error("failed send");
  release_quiet_a: assert property (
    tx_release |-> !tx_irq && !tx_complete_push) else $error("noisy");
  txon_stop_a: assert property (
    txon_clear |-> tx_irq && $past(tx_done && !tx_ok)) else $error("stop");
  cmd_onehot_a: assert property (
    $onehot0(mm_op) && !mm_op[0]) else $error("command not one-hot");
  cmd_cause_a: assert property (
    mm_op != 8'h00 |-> $past(wr_stb, 2) &&
    mm_op == (8'h01 << $past(wdata[7:5], 2))) else $error("command");
  load_target_a: assert property (
    ee_load_start |-> ee_targets inside {4'h8, 4'h7}) else $error("load");
  store_target_a: assert property (
    ee_store_start |-> ee_targets inside {4'h8, 4'h3}) else $error("save");
  cover property (mm_op[4]);
  cover property (ee_load_start);
  cover property (tx_release);
endmodule : pbcc_checker
bind pbcc_top pbcc_checker u_chk (.mclk, .srst, .ce, .wr_stb, .wdata,
  .rx_frame_done, .rx_crc_bad, .tx_done, .tx_ok, .rx_keep, .rx_free,
  .rx_irq, .tx_release, .tx_complete_push, .tx_irq, .txon_clear, .mm_op,
  .ee_load_start, .ee_store_start, .ee_targets);

/* File: pbcc_host.sv */
// Purpose: Host processor model issuing register reads and writes.
// Assumes: Strobes change just after a rising edge.
// Notes: Write data is inverted once released so stale data never helps.
`timescale 1ns/1ps
module pbcc_host (
  input wire logic mclk, // Clock.
  input wire logic [15:0] rdata, // Read data.
  output logic [3:0] addr, // Address.
  output logic [15:0] wdata, // Write data.
  output logic wr_stb, // Write strobe.
  output logic rd_stb // Read strobe.
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Other accesses are pointless until both EEPROM bits read low.
  task automatic ee_wait;
    logic [15:0] d;
    d = 16'h0003;
    for (int i = 0; i < 200 && d[1:0] != 2'b00; i++) begin
      rd(4'hc, d);
    end
  endtask : ee_wait
endmodule : pbcc_host

/* File: pbcc_top_bench.sv */
// Purpose: Self-checking bench for the packet buffer command control.
// Assumes: EEPROM time limit shortened to 50 cycles.
// Notes: Event inputs live in one vector indexed by name.
`timescale 1ns/1ps
module pbcc_top_bench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [13:0] ev = 14'h0;
  logic [3:0] addr, ee_targets;
  logic [15:0] wdata, rdata, d;
  logic wr_stb, rd_stb, rx_keep, rx_free, rx_irq, tx_release, tx_irq;
  logic tx_complete_push, tx_empty_irq, txon_clear, irq, ee_ld, ee_st;
  logic [7:0] mm_op;
  logic [5:0] mm_pkt;
  int miscompares = 0;
  int total_checks = 0;
  localparam int RXD = 0, BAD = 1, TXD = 2, TOK = 3, TQE = 4, TXON = 5;
  localparam int TSUC = 6, TW1 = 7, LNK = 8, ROL = 9, CRD = 10, EED = 11;
  localparam int AOK = 12, REL = 13;
  always #5 mclk = ~mclk;
  pbcc_host host (.mclk, .rdata, .addr, .wdata, .wr_stb, .rd_stb);
  pbcc_top #(.EE_LIMIT(50)) DUT (.mclk, .srst, .ce(1'b1), .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .rx_frame_done(ev[RXD]), .rx_crc_bad(ev[BAD]),
    .tx_done(ev[TXD]), .tx_ok(ev[TOK]), .tx_queue_empty(ev[TQE]),
    .transmitter_on(ev[TXON]), .tx_success_flag(ev[TSUC]),
    .txon_write_one(ev[TW1]), .link_ok(ev[LNK]), .counter_wrapped(ev[ROL]),
    .counter_reg_read(ev[CRD]), .ee_done(ev[EED]), .alloc_ok(ev[AOK]),
    .release_done(ev[REL]), .rx_keep, .rx_free, .rx_irq, .tx_release,
    .tx_complete_push, .tx_irq, .tx_empty_irq, .txon_clear,
    .merged_event_irq(irq), .mm_op, .mm_pkt, .ee_load_start(ee_ld),
    .ee_store_start(ee_st), .ee_targets);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
    #1;
  endtask : pulse
  // The merged irq trails its cause by two edges.
  task automatic w3;
    repeat (3) @(posedge mclk);
    #1;
  endtask : w3
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    host.rd(a, d);
    chk(d, exp);
  endtask : rchk
  task automatic t_reset;
    host.ee_wait;
    rchk(4'hc, 16'h1210);
    rchk(4'h0, 16'h0000);
    rchk(4'h4, 16'h0000);
    rchk(4'h8, 16'h0002);
    rchk(4'h2, 16'h0000);
    host.wr(4'hc, 16'hfffc);
    rchk(4'hc, 16'h5af4);
    host.wr(4'hc, 16'h48e0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_rxtx;
    ev[BAD] <= 1'b1;
    pulse(RXD);
    chk(16'({rx_keep, rx_free, rx_irq}), 16'h5);
    host.wr(4'hc, 16'h08e0);
    pulse(RXD);
    chk(16'({rx_keep, rx_free, rx_irq}), 16'h2);
    ev[TOK] <= 1'b1;
    pulse(TXD);
    d = 16'({tx_release, tx_complete_push, tx_irq, tx_empty_irq, txon_clear});
    chk(d, 16'h10);
    ev[TQE] <= 1'b1;
    pulse(TXD);
    d = 16'({tx_release, tx_complete_push, tx_irq, tx_empty_irq, txon_clear});
    chk(d, 16'h12);
    ev[TOK] <= 1'b0;
    pulse(TXD);
    d = 16'({tx_release, tx_complete_push, tx_irq, tx_empty_irq, txon_clear});
    chk(d, 16'h0d);
    $display("t_rxtx done");
  endtask : t_rxtx
  task automatic t_irq;
    ev[LNK] <= 1'b1;
    w3;
    chk(16'(irq), 16'h1);
    host.wr(4'hc, 16'h0860);
    w3;
    chk(16'(irq), 16'h0);
    ev[ROL] <= 1'b1;
    w3;
    chk(16'(irq), 16'h1);
    pulse(CRD);
    w3;
    chk(16'(irq), 16'h0);
    ev[TXON] <= 1'b1;
    w3;
    ev[TXON] <= 1'b0;
    w3;
    chk(16'(irq), 16'h1);
    pulse(TW1);
    w3;
    chk(16'(irq), 16'h0);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_cmd;
    for (int c = 1; c < 8; c++) begin
      host.wr(4'h4, 16'(c + 8));
      host.wr(4'h0, 16'(c << 5));
      // The command pulse stands only in the second cycle after the strobe's edge.
      @(posedge mclk);
      #1 chk({mm_op, 2'b00, mm_pkt},
        {8'h01 << c, 2'b00, 6'(c + 8)});
      rchk(4'h0, 16'(c == 4 || c == 5));
      rchk(4'h8, 16'(2 + (c == 4 || c == 5)));
      if (c == 1) pulse(AOK);
      pulse(REL);
      rchk(4'h8, 16'(c == 1 ? 0 : 2));
      rchk(4'h4, 16'(c == 2 ? 0 : c + 8));
    end
    $display("t_cmd done");
  endtask : t_cmd
  task automatic t_ee;
    host.wr(4'hc, 16'h0005);
    #1 chk(16'({ee_ld, ee_st}), 16'h1);
    host.wr(4'h4, 16'h0015);
    rchk(4'hc, 16'h0003);
    chk(16'(ee_targets), 16'h8);
    pulse(EED);
    host.ee_wait;
    rchk(4'h4, 16'h000f);
    host.wr(4'hc, 16'h0002);
    #1 chk(16'({ee_ld, ee_st}), 16'h2);
    rchk(4'hc, 16'h0003);
    chk(16'(ee_targets), 16'h7);
    pulse(EED);
    host.ee_wait;
    rchk(4'hc, 16'h1210);
    $display("t_ee done");
  endtask : t_ee
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_rxtx;
    t_irq;
    t_cmd;
    t_ee;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    finish_test;
  end
endmodule : pbcc_top_bench
